// ### ccp_pkg.sv
package ccp_pkg;

	// Register offsets (bus byte address = 4 * index, so every register is word aligned)
	localparam logic [7:0] IDX_PTR_HI   = 8'h83;
	localparam logic [7:0] IDX_STATUS   = 8'hd0;
	localparam logic [7:0] IDX_ACC      = 8'he0;
	localparam logic [7:0] IDX_PTR_LO   = 8'h82;
	localparam logic [7:0] IDX_RSV_TEST = 8'h84;

	localparam logic [7:0] RST_PTR_HI = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_ACC    = 8'h00;
	localparam logic [7:0] RST_PTR_LO = 8'h00;

	// Status word field positions
	localparam int POS_CARRY   = 7;
	localparam int POS_AUX     = 6;
	localparam int POS_USER0   = 5;
	localparam int POS_BANK_HI = 4;
	localparam int POS_BANK_LO = 3;
	localparam int POS_OVF     = 2;
	localparam int POS_USER1   = 1;
	localparam int POS_PARITY  = 0;

	localparam logic [7:0] STATUS_WR_MASK = 8'hfe;
	localparam logic [4:0] BANK_STRIDE    = 5'h08;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef enum logic [2:0] {
		ALU_NONE = 3'h1,
		ALU_ADD  = 3'h2,
		ALU_SUB  = 3'h4
	} ccp_alu_op_t;

	typedef struct packed {
		logic [7:0] ptr_hi;
		logic [7:0] ptr_lo;
		logic [7:0] status;
		logic [7:0] acc;
		logic       wr_pend;
		logic [7:0] wr_idx;
		logic       hit;
		logic [31:0] rdata;
	} ccp_state_t;

	typedef struct packed {
		logic [15:0] ptr_addr;
		logic [4:0]  bank_base;
	} ccp_addr_t;

endpackage : ccp_pkg

// ### ccp_alu.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_alu (
	input  wire logic [7:0]         a_in,
	input  wire logic [7:0]         b_in,
	input  wire logic               cin_in,
	input  wire ccp_pkg::ccp_alu_op_t op_in,
	output logic      [7:0]         res_out,
	output logic                    cy_out,
	output logic                    ac_out,
	output logic                    ov_out
);
	logic [8:0] full;
	logic [4:0] half;
	logic [7:0] bx;

	always_comb begin
		bx = (op_in == ccp_pkg::ALU_SUB) ? ~b_in : b_in;
		if (op_in == ccp_pkg::ALU_SUB) begin
			full = {1'b0, a_in} + {1'b0, bx} + {8'h00, ~cin_in};
			half = {1'b0, a_in[3:0]} + {1'b0, bx[3:0]} + {4'h0, ~cin_in};
			cy_out = ~full[8];
			ac_out = ~half[4];
		end else begin
			full = {1'b0, a_in} + {1'b0, bx} + {8'h00, cin_in};
			half = {1'b0, a_in[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin_in};
			cy_out = full[8];
			ac_out = half[4];
		end
		res_out = full[7:0];
		ov_out  = (a_in[7] == bx[7]) && (full[7] != a_in[7]);
	end
endmodule : ccp_alu
`default_nettype wire

// ### ccp_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// (RL1) Software never writes one to reserved bits; such bits are dropped anyway.
// (RL2) Reserved bits reset to zero and read back zero.
// (RL3) Upper pointer byte register holds bits 15..8 of the 16-bit data pointer.
// (RL4) Full 16-bit pointer is driven out as the indirect access address.
// (RL5) Accumulator at index 0xE0 is read/write and is ALU source and destination.
// (RL6) Two bank-select bits pick one of four eight-byte banks at 0x00..0x18.
module ccp_regs (
	input  wire logic                 CLK_SYS_IN,
	input  wire logic                 RST_N_IN,
	input  wire logic                 HSEL_IN,
	input  wire logic [31:0]          HADDR_IN,
	input  wire logic [1:0]           HTRANS_IN,
	input  wire logic                 HWRITE_IN,
	input  wire logic [2:0]           HSIZE_IN,
	input  wire logic [31:0]          HWDATA_IN,
	input  wire logic                 HREADY_IN,
	input  wire ccp_pkg::ccp_alu_op_t ALU_OP_IN,
	input  wire logic [7:0]           ALU_OPERAND_IN,
	output logic [31:0]               HRDATA_OUT,
	output logic                      HREADYOUT_OUT,
	output logic                      HRESP_OUT,
	output ccp_pkg::ccp_addr_t        ADDR_OUT,
	output logic [7:0]                ACC_OUT
);
	ccp_pkg::ccp_state_t s_q;
	ccp_pkg::ccp_state_t s_d;
	logic [7:0] alu_res;
	logic       alu_cy;
	logic       alu_ac;
	logic       alu_ov;
	logic [7:0] wbyte;
	logic [7:0] idx;
	logic       take;

	ccp_alu u_alu (
		.a_in    (s_q.acc),
		.b_in    (ALU_OPERAND_IN),
		.cin_in  (s_q.status[ccp_pkg::POS_CARRY]),
		.op_in   (ALU_OP_IN),
		.res_out (alu_res),
		.cy_out  (alu_cy),
		.ac_out  (alu_ac),
		.ov_out  (alu_ov)
	);

	always_comb begin
		s_d   = s_q;
		wbyte = HWDATA_IN[7:0];
		idx   = HADDR_IN[9:2];
		take  = HSEL_IN && HREADY_IN && (HTRANS_IN == ccp_pkg::HTRANS_NONSEQ);
		// Data phase of a previous write
		if (s_q.wr_pend) begin
			case (s_q.wr_idx)
				ccp_pkg::IDX_PTR_HI: s_d.ptr_hi = wbyte; // RL3
				ccp_pkg::IDX_PTR_LO: s_d.ptr_lo = wbyte;
				ccp_pkg::IDX_ACC:    s_d.acc = wbyte; // RL5
				ccp_pkg::IDX_STATUS: s_d.status = (wbyte & ccp_pkg::STATUS_WR_MASK)
					| (s_q.status & ~ccp_pkg::STATUS_WR_MASK);
				default: s_d.acc = s_d.acc; // RL2
			endcase
		end else if (ALU_OP_IN != ccp_pkg::ALU_NONE) begin
			s_d.acc = alu_res; // RL5
			s_d.status[ccp_pkg::POS_CARRY] = alu_cy;
			s_d.status[ccp_pkg::POS_AUX]   = alu_ac;
			s_d.status[ccp_pkg::POS_OVF]   = alu_ov;
		end
		// Parity always tracks the accumulator
		s_d.status[ccp_pkg::POS_PARITY] = ^s_d.acc;
		s_d.hit     = take && (HSIZE_IN == ccp_pkg::HSIZE_WORD);
		// Only whole-word writes are stored
		s_d.wr_pend = s_d.hit && HWRITE_IN;
		s_d.wr_idx  = idx;
		// Read sees a write still in its data phase
		if (take && !HWRITE_IN) begin
			case (idx)
				ccp_pkg::IDX_PTR_HI: s_d.rdata = {24'h000000, s_d.ptr_hi}; // RL3
				ccp_pkg::IDX_PTR_LO: s_d.rdata = {24'h000000, s_d.ptr_lo};
				ccp_pkg::IDX_STATUS: s_d.rdata = {24'h000000, s_d.status};
				ccp_pkg::IDX_ACC:    s_d.rdata = {24'h000000, s_d.acc}; // RL5
				default:             s_d.rdata = 32'h00000000; // RL2
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_q.ptr_hi  <= ccp_pkg::RST_PTR_HI; // RL2
			s_q.ptr_lo  <= ccp_pkg::RST_PTR_LO;
			s_q.status  <= ccp_pkg::RST_STATUS;
			s_q.acc     <= ccp_pkg::RST_ACC;
			s_q.wr_pend <= 1'b0;
			s_q.wr_idx  <= 8'h00;
			s_q.hit     <= 1'b0;
			s_q.rdata   <= 32'h00000000;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		HRDATA_OUT    = s_q.rdata;
		HREADYOUT_OUT = 1'b1;
		HRESP_OUT     = 1'b0;
		ADDR_OUT.ptr_addr  = {s_q.ptr_hi, s_q.ptr_lo}; // RL4
		ADDR_OUT.bank_base = {s_q.status[ccp_pkg::POS_BANK_HI:ccp_pkg::POS_BANK_LO], 3'h0}; // RL6
		ACC_OUT = s_q.acc;
	end
endmodule : ccp_regs
`default_nettype wire

// ### ccp_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_regs_chk (
	input wire logic               CLK_SYS_IN,
	input wire logic               RST_N_IN,
	input wire logic               HSEL_IN,
	input wire logic [31:0]        HADDR_IN,
	input wire logic [1:0]         HTRANS_IN,
	input wire logic               HWRITE_IN,
	input wire logic               HREADY_IN,
	input wire logic [31:0]        HWDATA_IN,
	input wire logic [31:0]        HRDATA_OUT,
	input wire ccp_pkg::ccp_addr_t ADDR_OUT,
	input wire logic [7:0]         ACC_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);
	logic go;
	logic whi;
	logic wlo;
	logic wst;
	assign go = HSEL_IN && HREADY_IN && HTRANS_IN == 2'h2;
	assign wst = go && HWRITE_IN && HADDR_IN == 32'h340;
	assign whi = go && HWRITE_IN && HADDR_IN == 32'h20c;
	assign wlo = go && HWRITE_IN && HADDR_IN == 32'h208;
	a_rsv_read_zero: assert property (go && !HWRITE_IN && HADDR_IN == 32'h210 |=> HRDATA_OUT == 32'h0)
		else $error("reserved read not zero");
	a_hi_byte_cause: assert property (!$stable(ADDR_OUT.ptr_addr[15:8]) |-> $past(whi) || $past(whi, 2))
		else $error("upper pointer byte moved without write");
	a_lo_byte_cause: assert property (!$stable(ADDR_OUT.ptr_addr[7:0]) |-> $past(wlo) || $past(wlo, 2))
		else $error("lower pointer byte moved without write");
	a_acc_write: assert property (go && HWRITE_IN && HADDR_IN == 32'h380 |=> ##1 ACC_OUT == $past(HWDATA_IN[7:0]))
		else $error("accumulator write lost");
	a_bank_cause: assert property (!$stable(ADDR_OUT.bank_base) |-> $past(wst, 2))
		else $error("bank base moved without status write");
	cover property (wst);
	cover property (whi);
	cover property (wlo);
	cover property (go && !HWRITE_IN);
endmodule : ccp_regs_chk
bind ccp_regs ccp_regs_chk ccp_regs_chk_i (
	.CLK_SYS_IN (CLK_SYS_IN),
	.RST_N_IN   (RST_N_IN),
	.HSEL_IN    (HSEL_IN),
	.HADDR_IN   (HADDR_IN),
	.HTRANS_IN  (HTRANS_IN),
	.HWRITE_IN  (HWRITE_IN),
	.HREADY_IN  (HREADY_IN),
	.HWDATA_IN  (HWDATA_IN),
	.HRDATA_OUT (HRDATA_OUT),
	.ADDR_OUT   (ADDR_OUT),
	.ACC_OUT    (ACC_OUT)
);
`default_nettype wire

// ### ccp_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_regs_test;
	logic clk = 0, rst_n = 0, sel = 0, wr = 0, rdy, rs;
	logic [1:0] tr = 0;
	logic [31:0] ad = 0, wd = 0, rd, rv;
	logic [7:0] acc;
	ccp_pkg::ccp_alu_op_t op = ccp_pkg::ALU_NONE;
	ccp_pkg::ccp_addr_t addr;
	int error_cnt = 0, total_checks = 0;
	always #5 clk = ~clk;
	ccp_regs ccp_regs_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(sel), .HADDR_IN(ad), .HTRANS_IN(tr),
		.HWRITE_IN(wr), .HSIZE_IN(3'h2), .HWDATA_IN(wd), .HREADY_IN(rdy), .ALU_OP_IN(op),
		.ALU_OPERAND_IN(8'h05), .HRDATA_OUT(rd), .HREADYOUT_OUT(rdy), .HRESP_OUT(rs), .ADDR_OUT(addr), .ACC_OUT(acc));
	task chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		ad <= a; wr <= w; tr <= 2'h2; sel <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		tr <= 2'h0; wd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		rv = rd;
	endtask : bus
	task t_reset;
		logic [31:0] ra[5] = '{32'h20c, 32'h208, 32'h340, 32'h380, 32'h210};
		foreach (ra[i]) begin
			bus(ra[i], 1'b0, 32'h0); chk("reset value", rv, 32'h0);
		end
	endtask : t_reset
	task t_acc;
		bus(32'h380, 1'b1, 32'ha7); bus(32'h380, 1'b0, 32'h0); chk("acc read", rv, 32'ha7);
		bus(32'h340, 1'b0, 32'h0); chk("parity", rv, 32'h1);
		chk("acc port", acc, 8'ha7);
		chk("response", rs, 1'b0);
	endtask : t_acc
	task t_alu;
		op <= ccp_pkg::ALU_ADD;
		@(posedge clk); op <= ccp_pkg::ALU_NONE;
		repeat (2) @(posedge clk); chk("alu sum", acc, 8'hac);
		op <= ccp_pkg::ALU_SUB;
		@(posedge clk); op <= ccp_pkg::ALU_NONE;
		@(posedge clk); chk("alu diff", acc, 8'ha7);
		op <= ccp_pkg::ALU_ADD;
		@(posedge clk); op <= ccp_pkg::ALU_NONE;
		@(posedge clk); chk("alu sum again", acc, 8'hac);
	endtask : t_alu
	task t_ptr;
		bus(32'h20c, 1'b1, 32'h12); bus(32'h208, 1'b1, 32'h34); bus(32'h20c, 1'b0, 32'h0);
		chk("hi byte", rv, 32'h12);
		@(posedge clk); chk("pointer", addr.ptr_addr, 16'h1234);
	endtask : t_ptr
	task t_bank;
		for (int b = 0; b < 4; b++) begin
			bus(32'h340, 1'b1, 32'(b << 3)); bus(32'h340, 1'b0, 32'h0);
			chk("status", rv, 32'(b << 3));
			@(posedge clk); chk("bank base", addr.bank_base, 32'(b * 8));
		end
	endtask : t_bank
	task t_rsv;
		bus(32'h210, 1'b1, 32'h0);
		bus(32'h210, 1'b0, 32'h0); chk("reserved", rv, 32'h0);
	endtask : t_rsv
	task t_midrst;
		bus(32'h380, 1'b1, 32'h5a);
		rst_n <= 1'b0;
		@(posedge clk); chk("acc in reset", acc, 8'h00);
		rst_n <= 1'b1;
		bus(32'h380, 1'b0, 32'h0); chk("acc after reset", rv, 32'h0);
		chk("pointer after reset", addr.ptr_addr, 16'h0000);
	endtask : t_midrst
	task print_verdict;
		if (error_cnt == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	initial begin
		#100000;
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset; t_acc; t_alu; t_ptr; t_bank; t_rsv; t_midrst;
		print_verdict;
	end
endmodule : ccp_regs_test
`default_nettype wire
